// File: rtl/bst_tap.sv
/* boundary scan tap: tap controller, 5-bit instruction register, bypass, id / user code,
 * boundary chain, user chain hooks, config bus access. assumes tck, tms, tdi, pads and the
 * mode pin are asynchronous to clk and tck is far slower (at least 8 clk per tck phase). */
// What this block does
// - five bit instruction; extest 00000, sample 00001, bypass 11111
// - codes 00010 and 00011 route the first and second user chains
// - 00100 reads configuration bus, 00101 loads configuration data
// - intest unsupported; extest captures core outputs of unused blocks
// - 01000 shifts out user code, 01001 shifts out identification code
// - public instructions work before configuration
// - after configuration public and user code instructions both work
// - user hooks show reset, update and shift tap states
// - each block gives input, output, enable cells, three bits each
// - input-only pins use only input cell; output-only use all three
// - every block, bonded or not, sits in one chain as tri-state cell
// - bit 0 tdo enable, bit 1 tdo output, top r-l, left t-b
// - then mode input cell, bottom l-r, right b-t, ending at tdi
// - bidirectional test stays usable after configuration
`timescale 1ns/1ps
module bst_tap
   import bst_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // scan port pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   // configuration side
   input wire logic configured,
   input wire logic [31:0] user_code,
   input wire logic cfg_rd_bit,
   output logic cfg_rd_next,
   output bst_cfg_s cfg_wr,
   output logic startup_step,
   // pads and core
   input wire logic mode_pin,
   input wire logic [N_IOB-1:0] pad_in,
   output logic [N_IOB-1:0] pad_out,
   output logic [N_IOB-1:0] pad_oe,
   input wire logic [N_IOB-1:0] core_out,
   input wire logic [N_IOB-1:0] core_oe,
   input wire logic [N_IOB-1:0] in_only,
   output logic [N_IOB-1:0] core_in,
   // user scan chains
   output bst_user_s user_hook,
   input wire logic user_tdo_one,
   input wire logic user_tdo_two
);
   // ***********************************************
   // pin synchronisers
   // ***********************************************
   logic [SYNC_W-1:0] meta_q, sync_q;
   logic tck_prev_q;
   logic tck_s, tms_s, tdi_s, mode_s;
   logic [N_IOB-1:0] pad_s;
   logic tck_rise, tck_fall;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (reset) begin
         meta_q <= '0;
         sync_q <= '0;
         tck_prev_q <= 1'b0;
      end else begin
         meta_q <= {pad_in, mode_pin, tdi, tms, tck};
         sync_q <= meta_q;
         tck_prev_q <= sync_q[0];
      end
   end

   assign tck_s = sync_q[0];
   assign tms_s = sync_q[1];
   assign tdi_s = sync_q[2];
   assign mode_s = sync_q[3];
   assign pad_s = sync_q[SYNC_W-1:4];
   assign tck_rise = tck_s & ~tck_prev_q;
   assign tck_fall = ~tck_s & tck_prev_q;
   // ***********************************************
   // tap controller
   // ***********************************************
   bst_tap_e state_q, state_d;

   // standard sixteen state walk; tms sampled with tck on the same stages
   always_comb begin
      unique case (state_q)
         TLR: state_d = tms_s ? TLR : RTI;
         RTI: state_d = tms_s ? SEL_DR : RTI;
         SEL_DR: state_d = tms_s ? SEL_IR : CAP_DR;
         CAP_DR: state_d = tms_s ? EX1_DR : SH_DR;
         SH_DR: state_d = tms_s ? EX1_DR : SH_DR;
         EX1_DR: state_d = tms_s ? UPD_DR : PA_DR;
         PA_DR: state_d = tms_s ? EX2_DR : PA_DR;
         EX2_DR: state_d = tms_s ? UPD_DR : SH_DR;
         UPD_DR: state_d = tms_s ? SEL_DR : RTI;
         SEL_IR: state_d = tms_s ? TLR : CAP_IR;
         CAP_IR: state_d = tms_s ? EX1_IR : SH_IR;
         SH_IR: state_d = tms_s ? EX1_IR : SH_IR;
         EX1_IR: state_d = tms_s ? UPD_IR : PA_IR;
         PA_IR: state_d = tms_s ? EX2_IR : PA_IR;
         EX2_IR: state_d = tms_s ? UPD_IR : SH_IR;
         UPD_IR: state_d = tms_s ? SEL_DR : RTI;
      endcase
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= TLR;
      end else if (tck_rise) begin
         state_q <= state_d;
      end
   end
   // ***********************************************
   // instruction register and decode
   // ***********************************************
   logic [IR_LEN-1:0] ir_sh_q, instr_q;
   bst_path_e path;
   logic user_ok;

   always_ff @(posedge clk) begin
      if (reset) begin
         ir_sh_q <= IR_CAPTURE;
         instr_q <= I_ID_READ;
      end else if (tck_rise) begin
         if (state_q == CAP_IR) begin
            ir_sh_q <= IR_CAPTURE;
         end else if (state_q == SH_IR) begin
            ir_sh_q <= {tdi_s, ir_sh_q[IR_LEN-1:1]};
         end
         if (state_d == TLR) begin
            instr_q <= I_ID_READ;
         end else if (state_q == UPD_IR) begin
            instr_q <= ir_sh_q;
         end
      end
   end

   // user codes only exist once configuration has installed them
   assign user_ok = configured;

   // public codes never look at configured, so they work at any time
   always_comb begin
      unique case (instr_q)
         I_EXTEST, I_SAMPLE: path = P_BSR;
         I_ID_READ: path = P_ID;
         I_USER_CODE_READ: path = user_ok ? P_ID : P_BYP;
         I_USER_CHAIN_ONE, I_USER_CHAIN_TWO: path = user_ok ? P_USER : P_BYP;
         I_CONFIG_READBACK: path = P_CFG_RD;
         I_CONFIG_LOAD: path = P_CFG_WR;
         default: path = P_BYP;
      endcase
   end
   // ***********************************************
   // data registers
   // ***********************************************
   logic byp_q;
   logic [31:0] id_sh_q;
   logic [BSR_LEN-1:0] bsr_sh_q, bsr_upd_q, bsr_cap;
   logic tdo_q, tdo_oe_q;

   // fixed ring cells: tdo pair at the tdo end, mode cell mid ring
   assign bsr_cap[TDO_EN_BIT] = tdo_oe_q;
   assign bsr_cap[TDO_OUT_BIT] = tdo_q;
   assign bsr_cap[MODE_BIT] = mode_s;

   always_ff @(posedge clk) begin
      if (reset) begin
         byp_q <= 1'b0;
         id_sh_q <= '0;
         bsr_sh_q <= '0;
      end else if (tck_rise) begin
         if (state_q == CAP_DR) begin
            byp_q <= 1'b0;
            id_sh_q <= (instr_q == I_ID_READ) ? ID_CODE : user_code;
            if (path == P_BSR) begin
               bsr_sh_q <= bsr_cap;
            end
         end else if (state_q == SH_DR) begin
            byp_q <= tdi_s;
            id_sh_q <= {tdi_s, id_sh_q[31:1]};
            if (path == P_BSR) begin
               bsr_sh_q <= {tdi_s, bsr_sh_q[BSR_LEN-1:1]};
            end
         end
      end
   end

   // update cells change only in update-dr, so preload under sample is safe
   always_ff @(posedge clk) begin
      if (reset) begin
         bsr_upd_q <= '0;
      end else if (tck_rise && state_q == UPD_DR && path == P_BSR) begin
         bsr_upd_q <= bsr_sh_q;
      end
   end
   // ***********************************************
   // pad cells, one per block in ring order
   // ***********************************************
   logic [N_IOB-1:0] pad_out_q, pad_oe_q, core_in_q;
   logic extest, outputs_off;

   // extest and the pad override do not depend on configured
   assign extest = (instr_q == I_EXTEST);
   assign outputs_off = (instr_q == I_OUTPUTS_OFF_BYPASS);

   for (genvar k = 0; k < N_IOB; k++) begin : g_iob
      localparam int B = IOB_BASE + 3 * k + ((k >= N_TOP + N_LEFT) ? 1 : 0);
      // captured out cell is the core output, so unused blocks expose logic
      assign bsr_cap[B + CELL_IN] = pad_s[k];
      assign bsr_cap[B + CELL_OUT] = core_out[k];
      assign bsr_cap[B + CELL_OE] = core_oe[k];

      always_ff @(posedge clk) begin
         if (reset) begin
            pad_out_q[k] <= 1'b0;
            pad_oe_q[k] <= 1'b0;
            core_in_q[k] <= 1'b0;
         end else begin
            core_in_q[k] <= pad_s[k];
            if (extest) begin
               pad_out_q[k] <= bsr_upd_q[B + CELL_OUT];
               pad_oe_q[k] <= bsr_upd_q[B + CELL_OE] & ~in_only[k];
            end else begin
               pad_out_q[k] <= core_out[k];
               pad_oe_q[k] <= core_oe[k] & ~outputs_off;
            end
         end
      end
   end
   // ***********************************************
   // tdo, user hooks, configuration bus
   // ***********************************************
   logic dr_lsb;
   bst_user_s user_q;
   bst_cfg_s cfg_q;
   logic cfg_rd_next_q, startup_q;

   always_comb begin
      unique case (path)
         P_BSR: dr_lsb = bsr_sh_q[0];
         P_ID: dr_lsb = id_sh_q[0];
         P_USER: dr_lsb = (instr_q == I_USER_CHAIN_ONE) ? user_tdo_one : user_tdo_two;
         P_CFG_RD: dr_lsb = cfg_rd_bit;
         default: dr_lsb = byp_q;
      endcase
   end

   // tdo moves on the falling edge so the tester samples a settled bit
   always_ff @(posedge clk) begin
      if (reset) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (tck_fall) begin
         tdo_q <= (state_q == SH_IR) ? ir_sh_q[0] : dr_lsb;
         tdo_oe_q <= (state_q == SH_IR) || (state_q == SH_DR);
      end
   end

   // hooks are levels that follow the tap state one clk late
   always_ff @(posedge clk) begin
      if (reset) begin
         user_q <= '0;
      end else begin
         user_q.reset <= (state_q == TLR);
         user_q.capture <= (state_q == CAP_DR);
         user_q.shift <= (state_q == SH_DR);
         user_q.update <= (state_q == UPD_DR);
         user_q.sel_one <= (path == P_USER) && (instr_q == I_USER_CHAIN_ONE);
         user_q.sel_two <= (path == P_USER) && (instr_q == I_USER_CHAIN_TWO);
         user_q.tdi <= tdi_s;
      end
   end

   // config strobes are one clk pulses per shifted bit; startup_step pulses once per run-idle rise while the startup code is loaded
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_q <= '0;
         cfg_rd_next_q <= 1'b0;
         startup_q <= 1'b0;
      end else begin
         cfg_q.valid <= tck_rise && state_q == SH_DR && path == P_CFG_WR;
         cfg_q.data <= tdi_s;
         cfg_rd_next_q <= tck_rise && state_q == SH_DR && path == P_CFG_RD;
         startup_q <= tck_rise && state_q == RTI && instr_q == I_STARTUP_CLOCKING;
      end
   end
   assign tdo = tdo_q;
   assign tdo_oe = tdo_oe_q;
   assign pad_out = pad_out_q;
   assign pad_oe = pad_oe_q;
   assign core_in = core_in_q;
   assign user_hook = user_q;
   assign cfg_wr = cfg_q;
   assign cfg_rd_next = cfg_rd_next_q;
   assign startup_step = startup_q;
   // ***********************************************
   // assertions
   // ***********************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   AST_TDO_ON_FALL: assert property (!tck_fall |=> $stable(tdo_q))
      else $error("tdo changed without a tck fall");
   AST_TLR_ID: assert property (state_q == TLR |-> instr_q == I_ID_READ)
      else $error("reset state without id instruction");
   AST_BYP_CAP: assert property (tck_rise && state_q == CAP_DR && path == P_BYP
      |=> !byp_q)
      else $error("bypass cell did not capture zero");
   AST_ID_CAP: assert property (tck_rise && state_q == CAP_DR && instr_q == I_ID_READ
      |=> id_sh_q == ID_CODE)
      else $error("id code not captured");
   AST_USER_GATE: assert property (!configured && instr_q == I_USER_CHAIN_ONE
      |-> path == P_BYP)
      else $error("user chain routed before configuration");
   AST_SHIFT_HOOK: assert property (state_q == SH_DR && $stable(state_q)
      |=> user_hook.shift)
      else $error("shift hook missing");
   AST_MODE_CAP: assert property (tck_rise && state_q == CAP_DR && instr_q == I_SAMPLE
      |=> bsr_sh_q[MODE_BIT] == $past(mode_s))
      else $error("mode cell capture wrong");
   AST_TDO_CELL: assert property (tck_rise && state_q == CAP_DR && instr_q == I_EXTEST
      |=> bsr_sh_q[TDO_EN_BIT] == $past(tdo_oe_q))
      else $error("tdo enable cell not at bit 0");
   AST_EXT_OUT: assert property (extest
      |=> pad_out[0] == $past(bsr_upd_q[IOB_BASE + CELL_OUT]))
      else $error("extest output not driven from update cell");
   AST_IN_ONLY: assert property (extest |=> (pad_oe & $past(in_only)) == '0)
      else $error("input-only pad driven in extest");
   AST_CFG_LOAD: assert property (tck_rise && state_q == SH_DR && path == P_CFG_WR
      |=> cfg_wr.valid && cfg_wr.data == $past(tdi_s) ##1 !cfg_wr.valid)
      else $error("config load strobe wrong");
   COV_EXTEST_UPD: cover property (tck_rise && state_q == UPD_DR && extest);
   COV_ID_SHIFT: cover property (tck_rise && state_q == SH_DR && instr_q == I_ID_READ);
   COV_CFG_LOAD: cover property (cfg_wr.valid);
   COV_USER_ONE: cover property (user_hook.sel_one && user_hook.shift);
endmodule

// File: rtl/bst_pkg.sv
/*
 * constants, instruction codes, tap states and carrier structs for the
 * boundary scan tap block.
 * assumes one system clock; the scan clock is only a sampled input.
 */
package bst_pkg;

   // ***********************************************
   // ring geometry
   // ***********************************************
   localparam int N_TOP = 2;
   localparam int N_LEFT = 2;
   localparam int N_BOT = 2;
   localparam int N_RIGHT = 2;
   localparam int N_IOB = N_TOP + N_LEFT + N_BOT + N_RIGHT;
   localparam int TDO_EN_BIT = 0;
   localparam int TDO_OUT_BIT = 1;
   localparam int IOB_BASE = 2;
   localparam int CELL_IN = 0;
   localparam int CELL_OUT = 1;
   localparam int CELL_OE = 2;
   localparam int MODE_BIT = IOB_BASE + 3 * (N_TOP + N_LEFT);
   localparam int BSR_LEN = IOB_BASE + 3 * N_IOB + 1;
   localparam int SYNC_W = N_IOB + 4;

   // ***********************************************
   // instruction register
   // ***********************************************
   localparam int IR_LEN = 5;
   localparam logic [4:0] IR_CAPTURE = 5'h01;
   localparam logic [4:0] I_EXTEST = 5'h00;
   localparam logic [4:0] I_SAMPLE = 5'h01;
   localparam logic [4:0] I_USER_CHAIN_ONE = 5'h02;
   localparam logic [4:0] I_USER_CHAIN_TWO = 5'h03;
   localparam logic [4:0] I_CONFIG_READBACK = 5'h04;
   localparam logic [4:0] I_CONFIG_LOAD = 5'h05;
   localparam logic [4:0] I_INTEST = 5'h07;
   localparam logic [4:0] I_USER_CODE_READ = 5'h08;
   localparam logic [4:0] I_ID_READ = 5'h09;
   localparam logic [4:0] I_OUTPUTS_OFF_BYPASS = 5'h0a;
   localparam logic [4:0] I_STARTUP_CLOCKING = 5'h0c;
   localparam logic [4:0] I_BYPASS = 5'h1f;
   // arbitrary identification value, lsb set as the scan standard wants
   localparam logic [31:0] ID_CODE = 32'h0a5a_5001;

   typedef enum logic [3:0] {
      TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
      SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
      UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
      EX1_IR = 4'hc, PA_IR = 4'hd, EX2_IR = 4'he, UPD_IR = 4'hf
   } bst_tap_e;

   typedef enum logic [2:0] {
      P_BYP = 3'h0, P_BSR = 3'h1, P_ID = 3'h2, P_USER = 3'h3,
      P_CFG_RD = 3'h4, P_CFG_WR = 3'h5
   } bst_path_e;

   typedef struct packed {
      logic reset;
      logic capture;
      logic shift;
      logic update;
      logic sel_one;
      logic sel_two;
      logic tdi;
   } bst_user_s;

   typedef struct packed {
      logic valid;
      logic data;
   } bst_cfg_s;

endpackage

// File: dv/bst_tester.sv
/*
 * scan tester model: drives tck, tms and tdi, samples the tdo line.
 * assumes clk is the bench clock; tck stands low between frames.
 */
`timescale 1ns/1ps
module bst_tester (
   // bench clock
   input wire logic clk,
   // scan pins
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo_line
);
   logic [63:0] dr_out;

   // idle pins until the first frame
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // one tck period, 8 clk low and 8 clk high; tdo taken just before the rise
   task automatic bit_cyc(input logic m, input logic d, output logic q);
      tms <= m;
      tdi <= d;
      repeat (8) @(negedge clk);
      q = tdo_line;
      tck <= 1'b1;
      repeat (8) @(negedge clk);
      tck <= 1'b0;
   endtask

   // state move; tdi is not meaningful here, so it toggles instead of holding
   task automatic mv(input logic m);
      logic q;
      bit_cyc(m, ~tdi, q);
   endtask

   // five ones reach test-logic-reset from anywhere, then park in run-idle
   task automatic tap_reset();
      repeat (5) mv(1'b1);
      mv(1'b0);
   endtask

   // shift n bits lsb first from run-idle, update, back to run-idle
   task automatic shift(input logic is_ir, input int n, input logic [63:0] din);
      logic q;
      mv(1'b1);
      if (is_ir) begin
         mv(1'b1);
      end
      mv(1'b0);
      mv(1'b0);
      dr_out = '0;
      for (int i = 0; i < n; i++) begin
         bit_cyc(i == n - 1, din[i], q);
         dr_out[i] = q;
      end
      mv(1'b1);
      mv(1'b0);
   endtask
endmodule

// File: dv/bst_tap_tb.sv
/*
 * self-checking bench for the boundary scan tap.
 * assumes the tester model drives the scan pins and tdo has a pull-up.
 */
`timescale 1ns/1ps
module bst_tap_tb
   import bst_pkg::*;
();
   typedef struct {
      logic [4:0] code;
      logic cfg;
      int len;
      logic [63:0] exp;
   } bst_row_s;
   localparam logic [63:0] DIN = {8{8'hb5}};
   localparam logic [63:0] BYP = 64'h6a;
   localparam logic [31:0] UCODE = 32'h1234_abcd;
   logic clk, reset, tck, tms, tdi, tdo, tdo_oe, tdo_line;
   logic configured, cfg_rd_bit, cfg_rd_next, startup_step, mode_pin;
   logic user_tdo_one, user_tdo_two, seen_shift, seen_upd;
   logic [31:0] user_code;
   logic [N_IOB-1:0] pad_in, pad_out, pad_oe, core_out, core_oe, in_only, core_in;
   logic [7:0] wr_bits;
   logic [63:0] pat;
   bst_cfg_s cfg_wr;
   bst_user_s user_hook;
   bst_row_s rows [14];
   int miscompares, tests_run, wr_cnt, rd_cnt, st_cnt;

   // ***********************************************
   // clock, pin wiring, design and tester
   // ***********************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // released tdo floats to the pull-up level
   assign tdo_line = tdo_oe ? tdo : 1'b1;

   bst_tap DUT (.clk, .reset, .tck, .tms, .tdi, .tdo, .tdo_oe, .configured,
      .user_code, .cfg_rd_bit, .cfg_rd_next, .cfg_wr, .startup_step, .mode_pin,
      .pad_in, .pad_out, .pad_oe, .core_out, .core_oe, .in_only, .core_in,
      .user_hook, .user_tdo_one, .user_tdo_two);
   bst_tester u_tst (.clk, .tck, .tms, .tdi, .tdo_line);

   // side-band monitor: config and startup pulses, user hook levels; cleared by reset
   always @(posedge clk) begin
      if (reset) begin
         {wr_cnt, rd_cnt, st_cnt} <= '0;
         wr_bits <= '0;
         {seen_shift, seen_upd} <= 2'b00;
      end else begin
         if (cfg_wr.valid) begin
            wr_cnt <= wr_cnt + 1;
            wr_bits <= {cfg_wr.data, wr_bits[7:1]};
         end
         if (cfg_rd_next) rd_cnt <= rd_cnt + 1;
         if (startup_step) st_cnt <= st_cnt + 1;
         if (user_hook.shift && user_hook.sel_one) seen_shift <= 1'b1;
         if (user_hook.update) seen_upd <= 1'b1;
      end
   end

   // ***********************************************
   // helpers
   // ***********************************************
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      if (miscompares == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // chain image: block k at base 2+3k before the mode cell, after it beyond
   function automatic logic [63:0] bsr(input logic [N_IOB-1:0] i, o, e, input logic m);
      logic [63:0] v;
      int p;
      v = '0;
      v[MODE_BIT] = m;
      for (int k = 0; k < N_IOB; k++) begin
         p = (k < N_TOP + N_LEFT) ? IOB_BASE + 3 * k : MODE_BIT + 1 + 3 * (k - N_TOP - N_LEFT);
         v[p + CELL_IN] = i[k];
         v[p + CELL_OUT] = o[k];
         v[p + CELL_OE] = e[k];
      end
      return v;
   endfunction

   task automatic ir(input logic [4:0] code);
      u_tst.shift(1'b1, IR_LEN, 64'(code));
      chk("ir capture", 64'(IR_CAPTURE), u_tst.dr_out);
   endtask

   // a hang is cut short well past the expected run of about 0.1 ms
   initial begin
      #300_000;
      miscompares++;
      print_verdict();
   end

   // ***********************************************
   // main sequence
   // ***********************************************
   initial begin
      {reset, configured, cfg_rd_bit, mode_pin} = 4'b1010;
      {user_tdo_one, user_tdo_two} = 2'b10;
      {miscompares, tests_run} = '0;
      {pad_in, core_out, core_oe, in_only} = '0;
      user_code = UCODE;
      rows = '{'{I_ID_READ, 0, 32, {32'h0, ID_CODE}}, '{I_BYPASS, 0, 8, BYP},
         '{I_USER_CODE_READ, 0, 8, BYP}, '{I_USER_CHAIN_ONE, 0, 8, BYP},
         '{I_INTEST, 1, 8, BYP}, '{I_OUTPUTS_OFF_BYPASS, 1, 8, BYP},
         '{I_STARTUP_CLOCKING, 1, 8, BYP}, '{5'h1e, 1, 8, BYP},
         '{I_USER_CODE_READ, 1, 32, {32'h0, UCODE}}, '{I_USER_CHAIN_ONE, 1, 8, 64'hff},
         '{I_USER_CHAIN_TWO, 1, 8, 64'h0}, '{I_CONFIG_READBACK, 1, 8, 64'hff},
         '{I_BYPASS, 1, 8, BYP}, '{I_ID_READ, 1, 32, {32'h0, ID_CODE}}};
      repeat (6) @(negedge clk);
      chk("tdo_oe in reset", 64'h0, 64'(tdo_oe));
      reset = 1'b0;
      repeat (3) @(negedge clk);
      chk("hook reset", 64'h1, 64'(user_hook.reset));
      u_tst.tap_reset();
      u_tst.shift(1'b0, 32, DIN);
      chk("id after reset", {32'h0, ID_CODE}, u_tst.dr_out);
      // instruction table, before and after configuration
      foreach (rows[r]) begin
         configured = rows[r].cfg;
         ir(rows[r].code);
         u_tst.shift(1'b0, rows[r].len, DIN);
         chk("dr out", rows[r].exp, u_tst.dr_out);
      end
      chk("readback pulses", 64'd8, 64'(rd_cnt));
      // one startup step per run-idle rise while the startup code is loaded
      chk("startup pulses", 64'd2, 64'(st_cnt));
      chk("hook shift", 64'h1, 64'(seen_shift));
      chk("hook update", 64'h1, 64'(seen_upd));
      // configuration load passes tdi bits out one by one
      ir(I_CONFIG_LOAD);
      u_tst.shift(1'b0, 8, 64'h9c);
      chk("load count", 64'd8, 64'(wr_cnt));
      chk("load data", 64'h9c, 64'(wr_bits));
      // sample: capture order, then preload cells for the external test
      {pad_in, core_out, core_oe, mode_pin} = {8'ha3, 8'h5c, 8'hf0, 1'b1};
      pat = bsr(8'h00, 8'h96, 8'h3c, 1'b0);
      ir(I_SAMPLE);
      u_tst.shift(1'b0, BSR_LEN, pat);
      chk("sample chain", bsr(pad_in, core_out, core_oe, 1'b1), u_tst.dr_out);
      chk("core in", 64'(pad_in), 64'(core_in));
      in_only = 8'h04;
      ir(I_EXTEST);
      chk("preload out", 64'h96, 64'(pad_out));
      chk("preload oe", 64'h38, 64'(pad_oe));
      u_tst.shift(1'b0, BSR_LEN, bsr(8'h00, 8'h69, 8'hff, 1'b0));
      chk("extest chain", bsr(pad_in, core_out, core_oe, 1'b1), u_tst.dr_out);
      chk("extest out", 64'h69, 64'(pad_out));
      chk("extest oe", 64'hfb, 64'(pad_oe));
      // reset in mid-run drops the pads; after it the id code is loaded and pads follow the core
      reset = 1'b1;
      repeat (3) @(negedge clk);
      chk("oe in reset", 64'h0, 64'(pad_oe));
      reset = 1'b0;
      repeat (3) @(negedge clk);
      chk("oe after reset", 64'(core_oe), 64'(pad_oe));
      u_tst.mv(1'b0);
      u_tst.shift(1'b0, 32, DIN);
      chk("id after second reset", {32'h0, ID_CODE}, u_tst.dr_out);
      print_verdict();
   end
endmodule
